//--- verilog/cbc_consts.vh
// constants for the capture channel b control block
// assumes a 32-bit byte-addressed plain register port
`ifndef CBC_CONSTS_VH
`define CBC_CONSTS_VH

// ***************************************
// register offsets
// ***************************************
`define CBC_ADDR_CTRL 8'h00
`define CBC_ADDR_STAT 8'h04

// ***************************************
// control field positions
// ***************************************
`define CBC_CMD_RESET 31
`define CBC_CMD_BLOCK 30
`define CBC_HORIZONTAL_COUNT_RESET_SELECT 16
`define CBC_EN 15
`define CBC_LONG_FIELD_DETECT_ENABLE 12
`define CBC_SHORT_FIELD_DETECT_ENABLE 11
`define CBC_CHROMA_RESAMPLE_ENABLE 10
`define CBC_SCALE 8
`define CBC_CON 7
`define CBC_FRAME 6
`define CBC_CF2 5
`define CBC_CF1 4
`define CBC_MODE_HI 1
`define CBC_MODE_LO 0

// ***************************************
// masks and reset values
// ***************************************
`define CBC_CTRL_MASK 32'h0001_9DF3
`define CBC_CTRL_RESET 32'h0000_0030
`define CBC_EN_MASK 32'h0000_8000

// ***************************************
// capture modes
// ***************************************
`define CBC_MODE_CODE 2'h0
`define CBC_MODE_RAW 2'h2

// ***************************************
// status field positions
// ***************************************
`define CBC_ST_ACTIVE 0
`define CBC_ST_DONE 1
`define CBC_ST_LONG 2
`define CBC_ST_SHORT 3

// ***************************************
// defaults
// ***************************************
`define CBC_LINES_PER_FIELD 16'h0107
`define CBC_HORIZONTAL_COUNTER_W 12
`define CBC_LCOUNT_W 16

`endif

//--- verilog/cbc_sync.v
// three-stage synchroniser for a pin level
// assumes a single clock, asynchronous active-high reset
`timescale 1ns/1ns
module cbc_sync (
   input wire clk_i,
   input wire sys_rst_i,
   input wire pin_i,
   output reg level_o
);

   reg s1_reg;
   reg s2_reg;
   reg s3_reg;

   // change accepted once stages two and three agree
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
         level_o <= 1'b0;
      end else begin
         s1_reg <= pin_i;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg) begin
            level_o <= s3_reg;
         end
      end
   end

endmodule

//--- verilog/cbc_capture_ctrl.v
// capture channel b control register and capture sequencer
// assumes a field/code decoder on clk_i supplying event pulses
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/1ns
`include "cbc_consts.vh"
module cbc_capture_ctrl #(
   parameter LINES_PER_FIELD = `CBC_LINES_PER_FIELD,
   parameter LINE_CTRL_ACTIVE_HIGH = 1
) (
   input wire clk_i,
   input wire sys_rst_i,
   input wire [7:0] addr_i,
   input wire [31:0] wr_data_i,
   input wire wr_i,
   input wire rd_i,
   output reg [31:0] rd_data_o,
   input wire line_control_input_i,
   input wire eav_i,
   input wire sav_i,
   input wire field_start_i,
   input wire field_end_i,
   input wire field_id_i,
   input wire block_start_i,
   input wire block_end_i,
   input wire [7:0] chroma_i,
   input wire chroma_valid_i,
   output reg [`CBC_HORIZONTAL_COUNTER_W-1:0] horizontal_counter_o,
   output reg capture_active_o,
   output reg capture_done_o,
   output reg long_field_o,
   output reg short_field_o,
   output reg [7:0] chroma_o,
   output reg chroma_valid_o,
   output reg scale_half_o,
   output reg [1:0] capture_mode_select_o
);

   // ***************************************
   // decode helpers
   // ***************************************
   function is_video;
      input [1:0] m;
      begin
         is_video = (m == `CBC_MODE_CODE) | (m == 2'h1);
      end
   endfunction

   localparam ST_IDLE = 2'd0;
   localparam ST_WAIT = 2'd1;
   localparam ST_CAPT = 2'd2;
   localparam ST_DONE = 2'd3;

   reg [31:0] capture_b_control_reg;
   reg [31:0] ctrl_next;
   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg armed_reg;
   reg armed_next;
   reg [3:0] status_reg;
   reg [3:0] status_next;
   reg line_prev_reg;
   reg [`CBC_LCOUNT_W-1:0] line_count_reg;
   reg [7:0] chroma_prev_reg;
   reg chroma_have_reg;
   wire line_level;
   wire line_act_edge;
   wire line_inact_edge;
   wire hreset;
   wire video;
   wire raw;
   wire capture_enable;
   wire start_ev;
   wire end_ev;
   wire field_sel;
   wire last_field;
   wire ctrl_wr;
   wire stat_wr;
   wire chan_reset;
   wire blk_cmd;
   wire long_hit;
   wire short_hit;
   wire [8:0] chroma_sum;

   cbc_sync u_line_sync (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .pin_i(line_control_input_i),
      .level_o(line_level)
   );

   assign capture_enable = capture_b_control_reg[`CBC_EN];
   assign video = is_video(capture_b_control_reg[`CBC_MODE_HI:`CBC_MODE_LO]);
   assign raw = capture_b_control_reg[`CBC_MODE_HI:`CBC_MODE_LO] == `CBC_MODE_RAW;
   assign ctrl_wr = wr_i & (addr_i == `CBC_ADDR_CTRL);
   assign stat_wr = wr_i & (addr_i == `CBC_ADDR_STAT);
   assign chan_reset = ctrl_wr & wr_data_i[`CBC_CMD_RESET];
   assign blk_cmd = ctrl_wr & wr_data_i[`CBC_CMD_BLOCK];

   // ***************************************
   // control register
   // ***************************************
   always @* begin
      ctrl_next = capture_b_control_reg;
      if (chan_reset) begin
         ctrl_next = capture_b_control_reg & ~`CBC_EN_MASK;
      end else if (ctrl_wr) begin
         if (capture_enable) begin
            // only the enable bit moves while capture is enabled
            ctrl_next = (capture_b_control_reg & ~`CBC_EN_MASK) | (wr_data_i & `CBC_EN_MASK);
         end else begin
            ctrl_next = wr_data_i & `CBC_CTRL_MASK;
         end
      end
   end

   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         capture_b_control_reg <= `CBC_CTRL_RESET;
      end else begin
         capture_b_control_reg <= ctrl_next;
      end
   end

   // ***************************************
   // horizontal counter
   // ***************************************
   assign line_act_edge = LINE_CTRL_ACTIVE_HIGH ? (line_level & ~line_prev_reg) :
                          (~line_level & line_prev_reg);
   assign line_inact_edge = LINE_CTRL_ACTIVE_HIGH ? (~line_level & line_prev_reg) :
                            (line_level & ~line_prev_reg);
   assign hreset = video & (capture_b_control_reg[`CBC_HORIZONTAL_COUNT_RESET_SELECT] ?
                   (sav_i | line_inact_edge) : (eav_i | line_act_edge));

   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         line_prev_reg <= 1'b0;
         horizontal_counter_o <= {`CBC_HORIZONTAL_COUNTER_W{1'b0}};
      end else begin
         line_prev_reg <= line_level;
         if (hreset | ~capture_enable) begin
            horizontal_counter_o <= {`CBC_HORIZONTAL_COUNTER_W{1'b0}};
         end else begin
            horizontal_counter_o <= horizontal_counter_o + 1'b1;
         end
      end
   end

   // ***************************************
   // capture sequencer
   // ***************************************
   assign start_ev = video ? field_start_i : (raw & block_start_i);
   assign end_ev = video ? field_end_i : (raw & block_end_i);
   assign field_sel = field_id_i ? capture_b_control_reg[`CBC_CF2] :
                      capture_b_control_reg[`CBC_CF1];
   // frame ends after field two, or field one when field two is skipped
   assign last_field = ~video | field_id_i | ~capture_b_control_reg[`CBC_CF2];

   always @* begin
      state_next = state_reg;
      armed_next = armed_reg | blk_cmd;
      case (state_reg)
         ST_IDLE: begin
            if (capture_enable) begin
               state_next = ST_WAIT;
               armed_next = capture_b_control_reg[`CBC_FRAME] | blk_cmd;
            end
         end
         ST_WAIT: begin
            if (start_ev & (capture_b_control_reg[`CBC_CON] | armed_reg) &
                (~video | field_sel)) begin
               state_next = ST_CAPT;
            end
         end
         ST_CAPT: begin
            if (end_ev) begin
               if (capture_b_control_reg[`CBC_CON]) begin
                  state_next = ST_WAIT;
               end else if (last_field) begin
                  state_next = ST_DONE;
                  armed_next = blk_cmd;
               end else begin
                  state_next = ST_WAIT;
               end
            end
         end
         ST_DONE: begin
            if (armed_reg | capture_b_control_reg[`CBC_CON]) begin
               state_next = ST_WAIT;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
      if (~capture_enable | chan_reset) begin
         state_next = ST_IDLE;
         armed_next = 1'b0;
      end
   end

   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_reg <= ST_IDLE;
         armed_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         armed_reg <= armed_next;
      end
   end

   // ***************************************
   // long and short field detection
   // ***************************************
   assign long_hit = video & capture_b_control_reg[`CBC_LONG_FIELD_DETECT_ENABLE] & field_end_i &
                     (line_count_reg > LINES_PER_FIELD);
   assign short_hit = video & capture_b_control_reg[`CBC_SHORT_FIELD_DETECT_ENABLE] & field_end_i &
                      (line_count_reg < LINES_PER_FIELD);

   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         line_count_reg <= {`CBC_LCOUNT_W{1'b0}};
         long_field_o <= 1'b0;
         short_field_o <= 1'b0;
      end else begin
         long_field_o <= long_hit;
         short_field_o <= short_hit;
         if (field_start_i | ~capture_enable) begin
            line_count_reg <= {`CBC_LCOUNT_W{1'b0}};
         end else if (hreset) begin
            line_count_reg <= line_count_reg + 1'b1;
         end
      end
   end

   // ***************************************
   // chroma resampling
   // ***************************************
   assign chroma_sum = {1'b0, chroma_prev_reg} + {1'b0, chroma_i};

   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         chroma_prev_reg <= 8'h00;
         chroma_have_reg <= 1'b0;
         chroma_o <= 8'h00;
         chroma_valid_o <= 1'b0;
      end else begin
         chroma_valid_o <= 1'b0;
         if (hreset) begin
            chroma_have_reg <= 1'b0;
         end else if (chroma_valid_i & (state_reg == ST_CAPT)) begin
            chroma_prev_reg <= chroma_i;
            chroma_have_reg <= 1'b1;
            if (video & capture_b_control_reg[`CBC_CHROMA_RESAMPLE_ENABLE]) begin
               // average neighbours; first sample of a line passes as is
               chroma_o <= chroma_have_reg ? chroma_sum[8:1] : chroma_i;
            end else begin
               chroma_o <= chroma_i;
            end
            chroma_valid_o <= 1'b1;
         end
      end
   end

   // ***************************************
   // status and outputs
   // ***************************************
   always @* begin
      status_next = status_reg;
      status_next[`CBC_ST_ACTIVE] = state_next == ST_CAPT;
      if (stat_wr) begin
         status_next[3:1] = status_reg[3:1] & ~wr_data_i[3:1];
      end
      // set beats clear
      if ((state_reg == ST_CAPT) & (state_next == ST_DONE)) begin
         status_next[`CBC_ST_DONE] = 1'b1;
      end
      if (long_hit) begin
         status_next[`CBC_ST_LONG] = 1'b1;
      end
      if (short_hit) begin
         status_next[`CBC_ST_SHORT] = 1'b1;
      end
   end

   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         status_reg <= 4'h0;
         capture_active_o <= 1'b0;
         capture_done_o <= 1'b0;
         scale_half_o <= 1'b0;
         capture_mode_select_o <= 2'h0;
      end else begin
         status_reg <= status_next;
         capture_active_o <= state_next == ST_CAPT;
         capture_done_o <= (state_reg == ST_CAPT) & (state_next == ST_DONE);
         scale_half_o <= ctrl_next[`CBC_SCALE];
         capture_mode_select_o <= ctrl_next[`CBC_MODE_HI:`CBC_MODE_LO];
      end
   end

   // ***************************************
   // register read port
   // ***************************************
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rd_data_o <= 32'h0000_0000;
      end else if (rd_i & (addr_i == `CBC_ADDR_CTRL)) begin
         rd_data_o <= capture_b_control_reg & `CBC_CTRL_MASK;
      end else if (rd_i & (addr_i == `CBC_ADDR_STAT)) begin
         rd_data_o <= {28'h000_0000, status_reg};
      end else begin
         rd_data_o <= 32'h0000_0000;
      end
   end

endmodule

//--- test/cbc_asserts.sv
// concurrent checks for the capture channel b control block
// assumes binding onto cbc_capture_ctrl, one clock, async high reset
`timescale 1ns/1ns
`include "cbc_consts.vh"
module cbc_asserts (
   input wire clk_i,
   input wire sys_rst_i,
   input wire [7:0] addr_i,
   input wire rd_i,
   input wire [31:0] rd_data_o,
   input wire eav_i,
   input wire sav_i,
   input wire field_start_i,
   input wire field_end_i,
   input wire block_start_i,
   input wire block_end_i,
   input wire chroma_valid_i,
   input wire [`CBC_HORIZONTAL_COUNTER_W-1:0] horizontal_counter_o,
   input wire capture_active_o,
   input wire capture_done_o,
   input wire long_field_o,
   input wire short_field_o,
   input wire chroma_valid_o,
   input wire [1:0] capture_mode_select_o
);
   default clocking dc @(posedge clk_i);
   endclocking
   default disable iff (sys_rst_i);
   // ***************************************
   // assertions
   // ***************************************
   chk_rsvd_zero: assert property (
      $past(rd_i) && $past(addr_i) == 8'h00 |-> (rd_data_o & ~`CBC_CTRL_MASK) == 32'h0)
      else $error("reserved control bits read nonzero");
   chk_mode_copy: assert property (
      $past(rd_i) && $past(addr_i) == 8'h00 |-> rd_data_o[1:0] == capture_mode_select_o)
      else $error("mode output differs from register");
   chk_horizontal_counter_reset: assert property (
      $past(eav_i && sav_i) && !$past(capture_mode_select_o[1]) |-> horizontal_counter_o == 0)
      else $error("horizontal counter not cleared");
   chk_active_cause: assert property (
      $rose(capture_active_o) |-> $past(field_start_i || block_start_i))
      else $error("capture started without start pulse");
   chk_done_cause: assert property (
      capture_done_o |-> $past(field_end_i || block_end_i) && !$past(capture_done_o))
      else $error("done without end pulse");
   chk_long_cause: assert property (
      long_field_o |-> $past(field_end_i))
      else $error("long field flag without field end");
   chk_short_cause: assert property (
      short_field_o |-> $past(field_end_i) && !long_field_o)
      else $error("short field flag without field end");
   chk_chroma_gate: assert property (
      chroma_valid_o |-> $past(chroma_valid_i && capture_active_o))
      else $error("chroma output outside capture");
   chk_mode_locked: assert property (
      $past(capture_active_o) && capture_active_o |-> $stable(capture_mode_select_o))
      else $error("mode changed during capture");
   cov_active: cover property ($rose(capture_active_o));
   cov_done: cover property (capture_done_o);
   cov_long: cover property (long_field_o);
endmodule

bind cbc_capture_ctrl cbc_asserts cbc_asserts_inst (
   .clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .rd_i(rd_i),
   .rd_data_o(rd_data_o), .eav_i(eav_i), .sav_i(sav_i), .field_start_i(field_start_i),
   .field_end_i(field_end_i), .block_start_i(block_start_i), .block_end_i(block_end_i),
   .chroma_valid_i(chroma_valid_i), .horizontal_counter_o(horizontal_counter_o),
   .capture_active_o(capture_active_o), .capture_done_o(capture_done_o),
   .long_field_o(long_field_o), .short_field_o(short_field_o),
   .chroma_valid_o(chroma_valid_o), .capture_mode_select_o(capture_mode_select_o)
);

//--- test/tb.sv
// self-checking bench for the capture channel b control block
// assumes the block alone on one 100 MHz clock, bench drives all pins
`timescale 1ns/1ns
`include "cbc_consts.vh"
module tb;
   // ***************************************
   // signals
   // ***************************************
   reg clk_i = 0;
   reg sys_rst_i = 1;
   reg wr_i = 0;
   reg rd_i = 0;
   reg field_id_i = 0;
   reg chroma_valid_i = 0;
   reg [7:0] addr_i = 0;
   reg [7:0] chroma_i = 0;
   reg [31:0] wr_data_i = 0;
   reg [5:0] ev_r = 0;
   reg line_i = 0;
   wire [31:0] rd_data_o;
   wire [`CBC_HORIZONTAL_COUNTER_W-1:0] horizontal_counter_o;
   wire capture_active_o;
   wire chroma_valid_o;
   wire [7:0] chroma_o;
   wire [1:0] capture_mode_select_o;
   wire capture_done_o;
   wire long_field_o;
   wire short_field_o;
   wire scale_half_o;
   integer err_total = 0;
   integer n_compared = 0;
   integer i;
   always #5 clk_i = ~clk_i;
   cbc_capture_ctrl #(.LINES_PER_FIELD(4)) cbc_capture_ctrl_inst (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
      .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .line_control_input_i(line_i),
      .eav_i(ev_r[5]), .sav_i(ev_r[4]), .field_start_i(ev_r[3]), .field_end_i(ev_r[2]),
      .field_id_i(field_id_i), .block_start_i(ev_r[1]), .block_end_i(ev_r[0]),
      .chroma_i(chroma_i), .chroma_valid_i(chroma_valid_i),
      .horizontal_counter_o(horizontal_counter_o), .capture_active_o(capture_active_o),
      .capture_done_o(capture_done_o), .long_field_o(long_field_o),
      .short_field_o(short_field_o), .chroma_o(chroma_o),
      .chroma_valid_o(chroma_valid_o), .scale_half_o(scale_half_o),
      .capture_mode_select_o(capture_mode_select_o)
   );
   // ***************************************
   // tasks
   // ***************************************
   task cmp(input [63:0] what, input [31:0] exp, input [31:0] got);
      begin
         n_compared = n_compared + 1;
         if (got !== exp) begin
            err_total = err_total + 1;
            $display("MISMATCH %0s exp %h got %h", what, exp, got);
         end
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      begin
         addr_i <= a;
         wr_data_i <= d;
         wr_i <= 1;
         @(posedge clk_i);
         wr_i <= 0;
         @(posedge clk_i);
      end
   endtask
   task rd(input [7:0] a, input [31:0] exp);
      begin
         addr_i <= a;
         rd_i <= 1;
         @(posedge clk_i);
         rd_i <= 0;
         @(posedge clk_i);
         cmp("rd_data", exp, rd_data_o);
      end
   endtask
   // event pulse: eav sav fstart fend bstart bend
   task ev(input [5:0] m);
      begin
         ev_r <= m;
         @(posedge clk_i);
         ev_r <= 6'h00;
         @(posedge clk_i);
      end
   endtask
   task arm(input [31:0] c);
      begin
         wr(8'h00, 32'h8000_0000);
         wr(8'h00, c);
         wr(8'h00, c | 32'h0000_8000);
      end
   endtask
   task fld(input id, input act, input [31:0] st);
      begin
         field_id_i <= id;
         ev(6'h08);
         cmp("active", {31'h0, act}, {31'h0, capture_active_o});
         ev(6'h04);
         cmp("done", {31'h0, st[1]}, {31'h0, capture_done_o});
         rd(8'h04, st);
         wr(8'h04, 32'h0000_000E);
      end
   endtask
   task lines(input integer n, input [31:0] st);
      begin
         ev(6'h08);
         repeat (n) ev(6'h20);
         ev(6'h04);
         cmp("long", {31'h0, st[2]}, {31'h0, long_field_o});
         cmp("short", {31'h0, st[3]}, {31'h0, short_field_o});
         rd(8'h04, st);
         wr(8'h04, 32'h0000_000E);
      end
   endtask
   task hz(input [5:0] m, input z);
      begin
         ev(m);
         cmp("hc_zero", {31'h0, z}, {31'h0, horizontal_counter_o == 12'h000});
      end
   endtask
   // line control pin edge, seen after the three-stage synchroniser
   task lc(input v, input z);
      begin
         line_i <= v;
         repeat (6) @(posedge clk_i);
         cmp("hc_line", {31'h0, z}, {31'h0, horizontal_counter_o == 12'h000});
      end
   endtask
   task chr(input [7:0] d, input [7:0] e);
      begin
         chroma_i <= d;
         chroma_valid_i <= 1;
         @(posedge clk_i);
         chroma_valid_i <= 0;
         @(posedge clk_i);
         cmp("chroma", {23'h0, 1'b1, e}, {23'h0, chroma_valid_o, chroma_o});
      end
   endtask
   task rs(input [31:0] c, input [7:0] e2);
      begin
         arm(c);
         field_id_i <= 0;
         ev(6'h08);
         ev(6'h20);
         chr(8'h10, 8'h10);
         chr(8'h30, e2);
      end
   endtask
   task test_done;
      begin
         $display("compared %0d mismatches %0d", n_compared, err_total);
         if (err_total == 0 && n_compared > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask
   // ***************************************
   // tests
   // ***************************************
   initial begin
      repeat (12) @(posedge clk_i);
      sys_rst_i <= 0;
      @(posedge clk_i);
      rd(8'h00, 32'h0000_0030);
      rd(8'h04, 32'h0000_0000);
      wr(8'h00, 32'h0FFF_7FFF);
      cmp("scale", 1, {31'h0, scale_half_o});
      rd(8'h00, 32'h0001_1DF3);
      wr(8'h08, 32'hFFFF_FFFF);
      rd(8'h08, 32'h0000_0000);
      rd(8'h00, 32'h0001_1DF3);
      for (i = 0; i < 4; i = i + 1) begin
         wr(8'h00, i);
         cmp("mode", i, {30'h0, capture_mode_select_o});
      end
      arm(32'h0000_0030);
      wr(8'h00, 32'h0000_9C72);
      rd(8'h00, 32'h0000_8030);
      wr(8'h00, 32'h8000_0000);
      rd(8'h00, 32'h0000_0030);
      arm(32'h0000_0070);
      fld(0, 1, 32'h0000_0000);
      fld(1, 1, 32'h0000_0002);
      arm(32'h0000_0050);
      fld(0, 1, 32'h0000_0002);
      arm(32'h0000_0060);
      fld(0, 0, 32'h0000_0000);
      fld(1, 1, 32'h0000_0002);
      arm(32'h0000_00B0);
      fld(0, 1, 32'h0000_0000);
      fld(1, 1, 32'h0000_0000);
      fld(0, 1, 32'h0000_0000);
      arm(32'h0000_0030);
      fld(0, 0, 32'h0000_0000);
      arm(32'h0000_0073);
      fld(0, 0, 32'h0000_0000);
      arm(32'h0000_0042);
      ev(6'h02);
      cmp("active", 1, {31'h0, capture_active_o});
      ev(6'h01);
      cmp("done", 1, {31'h0, capture_done_o});
      rd(8'h04, 32'h0000_0002);
      wr(8'h04, 32'h0000_000E);
      arm(32'h0000_0002);
      ev(6'h02);
      cmp("active", 0, {31'h0, capture_active_o});
      wr(8'h00, 32'h4000_8000);
      ev(6'h02);
      cmp("active", 1, {31'h0, capture_active_o});
      ev(6'h01);
      cmp("done", 1, {31'h0, capture_done_o});
      rd(8'h04, 32'h0000_0002);
      wr(8'h04, 32'h0000_000E);
      arm(32'h0000_0051);
      fld(0, 1, 32'h0000_0002);
      arm(32'h0000_1000);
      lines(5, 32'h0000_0004);
      lines(3, 32'h0000_0000);
      arm(32'h0000_0800);
      lines(3, 32'h0000_0008);
      lines(5, 32'h0000_0000);
      arm(32'h0000_0030);
      hz(6'h10, 0);
      hz(6'h20, 1);
      hz(6'h30, 1);
      lc(1, 1);
      lc(0, 0);
      arm(32'h0001_0030);
      hz(6'h20, 0);
      hz(6'h10, 1);
      lc(1, 0);
      lc(0, 1);
      rs(32'h0000_0470, 8'h20);
      rs(32'h0000_0070, 8'h30);
      test_done;
   end
   initial begin
      #200000;
      err_total = err_total + 1;
      test_done;
   end
endmodule
